// File: lcw_checker_asserts.sv
// Port-level checker for the legacy register set and window decoder.
// Assumes binding onto lcw_top; watches its top-level ports only.
module lcw_checker (
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic [15:0] I_LEGACY_BASE,
  input wire logic [19:0] I_SOCKET_BASE,
  input wire logic        I_IO_VALID,
  input wire logic [15:0] I_IO_ADDR,
  input wire logic        I_MEM_VALID,
  input wire logic [31:0] I_MEM_ADDR,
  input wire logic        O_IO_ACK,
  input wire logic        O_MEM_ACK,
  input wire logic        O_SOCK_SEL,
  input wire logic [10:0] O_SOCK_OFF,
  input wire logic        O_CARD_IO_SEL,
  input wire logic        O_CARD_MEM_SEL,
  input wire logic [25:0] O_CARD_ADDR,
  input wire logic        O_CARD_RESET
);
  // ==========================================================================
  // Socket window decode
  logic        sock_hit;
  logic [11:0] sock_off;
  assign sock_hit = I_MEM_VALID && (I_MEM_ADDR[31:12] == I_SOCKET_BASE);
  assign sock_off = I_MEM_ADDR[11:0];

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  // ==========================================================================
  // Properties
  AST_IO_PORT_ACK: assert property (
    I_IO_VALID && (I_IO_ADDR == I_LEGACY_BASE ||
    I_IO_ADDR == I_LEGACY_BASE + 16'h0001) |=> O_IO_ACK)
    else $error("index or data port cycle not acked");
  AST_IO_IDLE: assert property (
    !I_IO_VALID |=> !O_IO_ACK && !O_CARD_IO_SEL)
    else $error("io answer without io cycle");
  AST_ALIAS_ACK: assert property (
    sock_hit && sock_off >= 12'h800 && sock_off <= 12'h83F
    |=> O_MEM_ACK && !O_SOCK_SEL)
    else $error("register alias cycle not acked");
  AST_SOCK_SEL: assert property (
    sock_hit && !sock_off[11] |=> O_SOCK_SEL && !O_CARD_MEM_SEL &&
    O_SOCK_OFF == $past(sock_off[10:0]))
    else $error("socket register cycle wrong");
  AST_PAGE_END: assert property (
    sock_hit && sock_off > 12'h844 |=> !O_MEM_ACK && !O_SOCK_SEL)
    else $error("answer above page registers");
  AST_CARD_RST: assert property (
    $fell(I_RST) |-> O_CARD_RESET && !O_MEM_ACK)
    else $error("card not held in reset after reset");
  AST_MEM_SEL_CAUSE: assert property (
    O_CARD_MEM_SEL |-> $past(I_MEM_VALID) && !$past(sock_hit))
    else $error("memory window select without cause");
  AST_IO_CARD_WIDTH: assert property (
    O_CARD_IO_SEL && !O_CARD_MEM_SEL && !O_SOCK_SEL
    |-> O_CARD_ADDR[25:16] == 10'h000)
    else $error("io card address above 16 bits");
  AST_IO_SEL_CAUSE: assert property (
    O_CARD_IO_SEL || O_IO_ACK |-> $past(I_IO_VALID))
    else $error("io answer without cause");

  // Main scenarios
  cover property (O_CARD_IO_SEL);
  cover property (O_CARD_MEM_SEL);
  cover property (O_MEM_ACK && O_SOCK_SEL == 1'h0);
endmodule

// File: lcw_host_model.sv
// Host processor model: issues one-cycle io and memory strobes.
// Assumes the bench calls its tasks; drives at the falling edge.
module lcw_host_model (
  input  wire logic        i_clk,
  output logic             o_io_valid,
  output logic             o_io_write,
  output logic [15:0]      o_io_addr,
  output logic [7:0]       o_io_wdata,
  output logic             o_mem_valid,
  output logic             o_mem_write,
  output logic [31:0]      o_mem_addr,
  output logic [7:0]       o_mem_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    o_io_valid = 1'h0;
    o_mem_valid = 1'h0;
  end
  // I/O cycle, one strobe
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_io_valid = 1'h1;
    o_io_write = w;
    o_io_addr = a;
    o_io_wdata = d;
    @(negedge i_clk);
    o_io_valid = 1'h0;
    o_io_addr = ~a;  // Released lines show inverse
    o_io_wdata = ~d;
  endtask
  // Memory cycle, one strobe
  task automatic mem(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_mem_valid = 1'h1;
    o_mem_write = w;
    o_mem_addr = a;
    o_mem_wdata = d;
    @(negedge i_clk);
    o_mem_valid = 1'h0;
    o_mem_addr = ~a;
    o_mem_wdata = ~d;
  endtask
endmodule

// File: lcw_pkg.sv
// Constants shared by the legacy card register set and window decoder.
// Assumes one 40 MHz clock and host cycles presented as one-cycle strobes.
//
// Overview of operation
// R1 - Host writes a register offset into the index port at the I/O base.
// R2 - Data port at I/O base plus one reaches the register the index selects.
// R3 - The I/O base comes from the programmed legacy-mode base address value.
// R4 - Legacy register offsets run contiguously from 00h through 3Fh.
// R5 - The register set also appears in memory at socket offset 800h.
// R6 - Memory alias and index/data port reach the same register storage.
// R7 - Socket registers share the 4K memory window, starting at offset 0h.
// R8 - Control registers drive card reset, card type, routing and enables.
// R9 - Software should program interrupt routing to suit the signaling method.
// R10 - Two independent host I/O windows map onto card I/O space.
// R11 - Five independent host memory windows map onto card memory space.
// R12 - Each window has start, end and offset addresses in the register set.
// R13 - I/O window start and end resolve to a single byte.
// R14 - Memory windows compare whole 4-Kbyte pages only.
// R15 - Page registers sit at socket offsets 840h on, with no index offset.
// R16 - Access hits an enabled window when start <= address <= end.
// R17 - Card address is host address plus window offset, wrapping.
package lcw_pkg;

  // ==========================================================================
  // Sizes
  localparam int LCR_DEPTH  = 64;
  localparam int IO_WINS    = 2;
  localparam int MEM_WINS   = 5;
  localparam int CARD_AW    = 26;
  localparam int PAGE_LSB   = 12;

  // ==========================================================================
  // Register set offsets
  localparam logic [5:0] OFF_ID       = 6'h00;
  localparam logic [5:0] OFF_INT_CTL  = 6'h03;
  localparam logic [5:0] OFF_CSC_CFG  = 6'h05;
  localparam logic [5:0] OFF_WIN_ENA  = 6'h06;
  localparam logic [5:0] OFF_IO_BASE  = 6'h08;   // Start lo of I/O window 0
  localparam logic [5:0] OFF_IO_STEP  = 6'h04;
  localparam logic [5:0] OFF_IO_OFS   = 6'h36;   // Offset lo of I/O window 0
  localparam logic [5:0] OFF_IO_OSTEP = 6'h02;
  localparam logic [5:0] OFF_MEM_BASE = 6'h10;   // Start lo of memory window 0
  localparam logic [5:0] OFF_MEM_STEP = 6'h08;
  localparam logic [5:0] OFF_END      = 6'h02;   // End pair after start pair
  localparam logic [5:0] OFF_MOFS     = 6'h04;   // Offset pair after start

  // ==========================================================================
  // Socket memory window layout
  localparam logic [11:0] SOCK_LCR_FIRST  = 12'h800;
  localparam logic [11:0] SOCK_LCR_LAST   = 12'h83F;
  localparam logic [11:0] SOCK_PAGE_FIRST = 12'h840;

  // ==========================================================================
  // Field positions
  localparam int ENA_MEM_LSB    = 0;    // Enable bits of memory windows
  localparam int ENA_IO_LSB     = 6;    // Enable bits of I/O windows
  localparam int CTL_RESET_N    = 6;    // Zero holds the card in reset
  localparam int CTL_IO_TYPE    = 5;    // One selects an I/O card
  localparam int ROUTE_W        = 4;
  localparam int MEM_START_HI_W = 4;
  localparam int MEM_OFS_HI_W   = 6;

  // Arbitrary identification value
  localparam logic [7:0] ID_VALUE = 8'h5A;
  localparam logic [7:0] BYTE_RST = 8'h00;

endpackage

// File: lcw_top.sv
// Legacy card register set with index/data and memory-alias access, plus
// the two I/O and five memory windows that map host cycles onto the card.
// Assumes host cycles are one-cycle strobes on I_CLK and that the base
// address values are stable configuration levels from the same domain.
module lcw_top (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic [15:0] I_LEGACY_BASE,
  input  wire logic [19:0] I_SOCKET_BASE,
  input  wire logic        I_IO_VALID,
  input  wire logic        I_IO_WRITE,
  input  wire logic [15:0] I_IO_ADDR,
  input  wire logic [7:0]  I_IO_WDATA,
  input  wire logic        I_MEM_VALID,
  input  wire logic        I_MEM_WRITE,
  input  wire logic [31:0] I_MEM_ADDR,
  input  wire logic [7:0]  I_MEM_WDATA,
  output logic             O_IO_ACK,
  output logic [7:0]       O_IO_RDATA,
  output logic             O_MEM_ACK,
  output logic [7:0]       O_MEM_RDATA,
  output logic             O_SOCK_SEL,
  output logic [10:0]      O_SOCK_OFF,
  output logic             O_CARD_IO_SEL,
  output logic             O_CARD_MEM_SEL,
  output logic             O_CARD_WRITE,
  output logic [25:0]      O_CARD_ADDR,
  output logic [7:0]       O_WDATA,
  output logic             O_CARD_RESET,
  output logic             O_CARD_IO_TYPE,
  output logic [3:0]       O_IRQ_ROUTE,
  output logic [7:0]       O_CSC_CFG
);

  // ==========================================================================
  // Storage
  logic [7:0] lcr_reg [lcw_pkg::LCR_DEPTH];
  logic [7:0] page_reg [lcw_pkg::MEM_WINS];
  logic [7:0] index_reg;

  // Byte of the register set as the host sees it
  function automatic logic [7:0] lcr_rd(input logic [5:0] idx);
    lcr_rd = (idx == lcw_pkg::OFF_ID) ? lcw_pkg::ID_VALUE : lcr_reg[idx];
  endfunction

  // Little-endian 16-bit pair starting at idx
  function automatic logic [15:0] pair(input logic [5:0] idx);
    pair = {lcr_reg[6'(idx + 6'h01)], lcr_reg[idx]};
  endfunction

  // Inclusive range test shared by both window kinds
  function automatic logic in_range(input logic [19:0] a,
                                    input logic [19:0] lo,
                                    input logic [19:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // ==========================================================================
  // Host I/O decode
  logic        io_index_hit;
  logic        io_data_hit;
  logic        io_data_ok;

  assign io_index_hit = I_IO_VALID
                        && (I_IO_ADDR == I_LEGACY_BASE);       // [R1] [R3]
  assign io_data_hit  = I_IO_VALID
                        && (I_IO_ADDR == 16'(I_LEGACY_BASE + 16'h0001)); // [R2]
  assign io_data_ok   = (index_reg < 8'(lcw_pkg::LCR_DEPTH));  // [R4]

  // ==========================================================================
  // Host memory decode inside the socket 4K window
  logic        mem_in_sock;
  logic [11:0] mem_off;
  logic        mem_sock_hit;
  logic        mem_lcr_hit;
  logic        mem_page_hit;
  logic [2:0]  mem_page_idx;

  assign mem_in_sock  = I_MEM_VALID
                        && (I_MEM_ADDR[31:lcw_pkg::PAGE_LSB] == I_SOCKET_BASE);
  assign mem_off      = I_MEM_ADDR[11:0];
  assign mem_sock_hit = mem_in_sock && (mem_off < lcw_pkg::SOCK_LCR_FIRST); // [R7]
  assign mem_lcr_hit  = mem_in_sock && (mem_off >= lcw_pkg::SOCK_LCR_FIRST)
                        && (mem_off <= lcw_pkg::SOCK_LCR_LAST);   // [R5]
  assign mem_page_idx = 3'(mem_off - lcw_pkg::SOCK_PAGE_FIRST);
  assign mem_page_hit = mem_in_sock && (mem_off >= lcw_pkg::SOCK_PAGE_FIRST)
                        && (mem_off < 12'(lcw_pkg::SOCK_PAGE_FIRST
                                          + 12'(lcw_pkg::MEM_WINS))); // [R15]

  // ==========================================================================
  // Single write port into the register set; memory wins a same-cycle clash
  logic       wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;

  always_comb begin
    if (mem_lcr_hit && I_MEM_WRITE) begin
      wr_en   = 1'b1;
      wr_idx  = mem_off[5:0];                                  // [R6]
      wr_data = I_MEM_WDATA;
    end else begin
      wr_en   = io_data_hit && I_IO_WRITE && io_data_ok;       // [R2]
      wr_idx  = index_reg[5:0];
      wr_data = I_IO_WDATA;
    end
  end

  // Index register
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      index_reg <= lcw_pkg::BYTE_RST;
    end else if (io_index_hit && I_IO_WRITE) begin
      index_reg <= I_IO_WDATA;                                 // [R1]
    end
  end

  // Register set bytes, one storage for both access paths
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      for (int i = 0; i < lcw_pkg::LCR_DEPTH; i++) begin
        lcr_reg[i] <= lcw_pkg::BYTE_RST;
      end
    end else if (wr_en && (wr_idx != lcw_pkg::OFF_ID)) begin
      lcr_reg[wr_idx] <= wr_data;                              // [R6] [R12]
    end
  end

  // Memory window page bytes, memory path only
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      for (int i = 0; i < lcw_pkg::MEM_WINS; i++) begin
        page_reg[i] <= lcw_pkg::BYTE_RST;
      end
    end else if (mem_page_hit && I_MEM_WRITE) begin
      page_reg[mem_page_idx] <= I_MEM_WDATA;                   // [R15]
    end
  end

  // ==========================================================================
  // I/O window match and translation
  logic        io_win_hit;
  logic [15:0] io_card_addr;

  always_comb begin
    logic [5:0]  base;
    logic [5:0]  obase;
    base         = 6'h00;
    obase        = 6'h00;
    io_win_hit   = 1'b0;
    io_card_addr = 16'h0000;
    for (int w = lcw_pkg::IO_WINS - 1; w >= 0; w--) begin
      base  = 6'(lcw_pkg::OFF_IO_BASE + 6'(w) * lcw_pkg::OFF_IO_STEP);
      obase = 6'(lcw_pkg::OFF_IO_OFS + 6'(w) * lcw_pkg::OFF_IO_OSTEP);
      if (lcr_reg[lcw_pkg::OFF_WIN_ENA][lcw_pkg::ENA_IO_LSB + w]   // [R10]
          && in_range({4'h0, I_IO_ADDR},                           // [R13]
                      {4'h0, pair(base)},
                      {4'h0, pair(6'(base + lcw_pkg::OFF_END))})) begin // [R16]
        io_win_hit   = 1'b1;
        io_card_addr = 16'(I_IO_ADDR + pair(obase));           // [R17]
      end
    end
  end

  // ==========================================================================
  // Memory window match and translation in whole pages
  logic        mem_win_hit;
  logic [13:0] mem_card_page;

  always_comb begin
    logic [5:0]  base;
    logic [15:0] st;
    logic [15:0] en;
    logic [15:0] of;
    base          = 6'h00;
    st            = 16'h0000;
    en            = 16'h0000;
    of            = 16'h0000;
    mem_win_hit   = 1'b0;
    mem_card_page = 14'h0000;
    for (int w = lcw_pkg::MEM_WINS - 1; w >= 0; w--) begin
      base = 6'(lcw_pkg::OFF_MEM_BASE + 6'(w) * lcw_pkg::OFF_MEM_STEP);
      st   = pair(base);
      en   = pair(6'(base + lcw_pkg::OFF_END));
      of   = pair(6'(base + lcw_pkg::OFF_MOFS));
      if (lcr_reg[lcw_pkg::OFF_WIN_ENA][lcw_pkg::ENA_MEM_LSB + w]  // [R11]
          && in_range(I_MEM_ADDR[31:lcw_pkg::PAGE_LSB],            // [R14]
                      {page_reg[w], st[lcw_pkg::MEM_START_HI_W+7:0]},
                      {page_reg[w], en[lcw_pkg::MEM_START_HI_W+7:0]})) begin
        mem_win_hit   = 1'b1;                                  // [R16]
        mem_card_page = 14'(I_MEM_ADDR[25:lcw_pkg::PAGE_LSB]
                            + of[lcw_pkg::MEM_OFS_HI_W+7:0]);  // [R17]
      end
    end
  end

  // ==========================================================================
  // Host answers for index/data, alias and page register cycles
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_IO_ACK   <= 1'b0;
      O_IO_RDATA <= lcw_pkg::BYTE_RST;
    end else begin
      O_IO_ACK   <= io_index_hit || io_data_hit;
      if (io_index_hit) begin
        O_IO_RDATA <= index_reg;
      end else if (io_data_hit) begin
        O_IO_RDATA <= io_data_ok ? lcr_rd(index_reg[5:0])     // [R2]
                                 : lcw_pkg::BYTE_RST;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_MEM_ACK   <= 1'b0;
      O_MEM_RDATA <= lcw_pkg::BYTE_RST;
    end else begin
      O_MEM_ACK   <= mem_lcr_hit || mem_page_hit;
      if (mem_lcr_hit) begin
        O_MEM_RDATA <= lcr_rd(mem_off[5:0]);                   // [R6]
      end else if (mem_page_hit) begin
        O_MEM_RDATA <= page_reg[mem_page_idx];                 // [R15]
      end
    end
  end

  // ==========================================================================
  // Forwarded cycles: socket registers and card windows
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_SOCK_SEL     <= 1'b0;
      O_SOCK_OFF     <= 11'h000;
      O_CARD_IO_SEL  <= 1'b0;
      O_CARD_MEM_SEL <= 1'b0;
      O_CARD_WRITE   <= 1'b0;
      O_CARD_ADDR    <= 26'h0000000;
      O_WDATA        <= lcw_pkg::BYTE_RST;
    end else begin
      O_SOCK_SEL     <= mem_sock_hit;                          // [R7]
      O_CARD_IO_SEL  <= I_IO_VALID && !io_index_hit && !io_data_hit
                        && io_win_hit;
      O_CARD_MEM_SEL <= I_MEM_VALID && !mem_in_sock && mem_win_hit;
      if (mem_sock_hit) begin
        O_SOCK_OFF   <= mem_off[10:0];
        O_CARD_WRITE <= I_MEM_WRITE;
        O_WDATA      <= I_MEM_WDATA;
      end else if (I_MEM_VALID && !mem_in_sock && mem_win_hit) begin
        O_CARD_ADDR  <= {mem_card_page, mem_off};
        O_CARD_WRITE <= I_MEM_WRITE;
        O_WDATA      <= I_MEM_WDATA;
      end else if (I_IO_VALID && !io_index_hit && !io_data_hit
                   && io_win_hit) begin
        O_CARD_ADDR  <= {10'h000, io_card_addr};
        O_CARD_WRITE <= I_IO_WRITE;
        O_WDATA      <= I_IO_WDATA;
      end
    end
  end

  // ==========================================================================
  // Card control levels
  assign O_CARD_RESET   = !lcr_reg[lcw_pkg::OFF_INT_CTL][lcw_pkg::CTL_RESET_N];
  assign O_CARD_IO_TYPE = lcr_reg[lcw_pkg::OFF_INT_CTL][lcw_pkg::CTL_IO_TYPE];
  assign O_IRQ_ROUTE    = lcr_reg[lcw_pkg::OFF_INT_CTL][lcw_pkg::ROUTE_W-1:0];
  assign O_CSC_CFG      = lcr_reg[lcw_pkg::OFF_CSC_CFG];         // [R8]

endmodule

// File: legacy_card_window_access_test.sv
// Self-checking bench for lcw_top with a host model on its far side.
// Assumes a 40 MHz clock and the package lcw_pkg compiled first.
module legacy_card_window_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        I_CLK, I_RST, I_IO_VALID, I_IO_WRITE, I_MEM_VALID, I_MEM_WRITE;
  logic        O_IO_ACK, O_MEM_ACK, O_SOCK_SEL, O_CARD_IO_SEL, O_CARD_MEM_SEL;
  logic        O_CARD_WRITE, O_CARD_RESET, O_CARD_IO_TYPE;
  logic [15:0] I_LEGACY_BASE, I_IO_ADDR;
  logic [19:0] I_SOCKET_BASE;
  logic [31:0] I_MEM_ADDR;
  logic [7:0]  I_IO_WDATA, I_MEM_WDATA, O_IO_RDATA, O_MEM_RDATA, O_WDATA;
  logic [7:0]  O_CSC_CFG;
  logic [10:0] O_SOCK_OFF;
  logic [25:0] O_CARD_ADDR;
  logic [3:0]  O_IRQ_ROUTE;
  int          miscompares, samples_checked, cycles;
  integer      seed = 32'he24f54df;

  lcw_top i_lcw_top (.I_CLK, .I_RST, .I_LEGACY_BASE, .I_SOCKET_BASE,
    .I_IO_VALID, .I_IO_WRITE, .I_IO_ADDR, .I_IO_WDATA, .I_MEM_VALID,
    .I_MEM_WRITE, .I_MEM_ADDR, .I_MEM_WDATA, .O_IO_ACK, .O_IO_RDATA,
    .O_MEM_ACK, .O_MEM_RDATA, .O_SOCK_SEL, .O_SOCK_OFF, .O_CARD_IO_SEL,
    .O_CARD_MEM_SEL, .O_CARD_WRITE, .O_CARD_ADDR, .O_WDATA, .O_CARD_RESET,
    .O_CARD_IO_TYPE, .O_IRQ_ROUTE, .O_CSC_CFG);
  lcw_host_model i_lcw_host_model (.i_clk(I_CLK), .o_io_valid(I_IO_VALID),
    .o_io_write(I_IO_WRITE), .o_io_addr(I_IO_ADDR), .o_io_wdata(I_IO_WDATA),
    .o_mem_valid(I_MEM_VALID), .o_mem_write(I_MEM_WRITE),
    .o_mem_addr(I_MEM_ADDR), .o_mem_wdata(I_MEM_WDATA));

  // ==========================================================================
  // Clock and hang guard
  initial begin
    I_CLK = 1'h0;
    forever #12.5 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] off, input logic [7:0] d);
    i_lcw_host_model.io(1'h1, I_LEGACY_BASE, {2'h0, off});
    i_lcw_host_model.io(1'h1, I_LEGACY_BASE + 16'h0001, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    i_lcw_host_model.io(1'h1, I_LEGACY_BASE, idx);
    i_lcw_host_model.io(1'h0, I_LEGACY_BASE + 16'h0001, 8'h00);
    chk(O_IO_ACK, 1'h1);
    chk(O_IO_RDATA, e);
  endtask
  task automatic do_reset;
    I_RST = 1'h1;
    repeat (2) @(negedge I_CLK);
    I_RST = 1'h0;
  endtask
  function automatic logic [25:0] mem_card(input logic [31:0] a,
                                           input logic [13:0] o);
    return {a[25:12] + o, a[11:0]};
  endfunction
  task automatic conclude;
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0]  d, sl, hi, ub, ena, dl [4];
    logic [15:0] ofs, a;
    logic [31:0] ma;
    logic [5:0]  off, wv;
    dl = '{8'h00, 8'h10, 8'h11, 8'hFF};  // Start, end, past end, before
    I_RST = 1'h1;
    I_LEGACY_BASE = 16'h03E0;
    I_SOCKET_BASE = 20'hFFFFF;
    do_reset();
    chk(O_CARD_RESET, 1'h1);
    wr(6'h00, 8'hFF);
    rd(8'h00, lcw_pkg::ID_VALUE);
    rd(8'h40, 8'h00);
    $display("reset and index test done");
    for (int i = 8; i < 20; i++) begin
      off = (i < 16) ? 6'(i) : 6'(i + 32'h26);
      d = 8'($random(seed));
      ma = {I_SOCKET_BASE, 6'h20, off};
      if (i[0]) begin
        i_lcw_host_model.mem(1'h1, ma, d);
        rd({2'h0, off}, d);
      end else begin
        wr(off, d);
        i_lcw_host_model.mem(1'h0, ma, 8'h00);
        chk(O_MEM_ACK, 1'h1);
        chk(O_MEM_RDATA, d);
      end
    end
    d = 8'($random(seed));
    wr(lcw_pkg::OFF_INT_CTL, d);
    chk(O_CARD_RESET, !d[6]);
    chk(O_CARD_IO_TYPE, d[5]);
    chk(O_IRQ_ROUTE, d[3:0]);
    wr(lcw_pkg::OFF_CSC_CFG, d);
    chk(O_CSC_CFG, d);
    $display("alias and control test done");
    ena = 8'h00;
    for (int w = 0; w < 7; w++) begin
      wv = 6'(w);
      sl = 8'($random(seed)) & 8'h7F;
      hi = 8'h40 + 8'(w);
      ub = (w < 2) ? hi : {4'h0, hi[3:0]};  // Full I/O high byte or start_hi
      ena = ena | ((w < 2) ? 8'(8'h40 << w) : 8'(8'h01 << (w - 2)));
      ofs = 16'($random(seed));
      if (w < 2) begin
        off = 6'h08 + wv * 6'h04;
        wr(6'h36 + wv * 6'h02, ofs[7:0]);
        wr(6'h37 + wv * 6'h02, ofs[15:8]);
      end else begin
        off = 6'h10 + (wv - 6'h02) * 6'h08;
        wr(off + 6'h04, ofs[7:0]);
        wr(off + 6'h05, ofs[15:8]);
        ma = {I_SOCKET_BASE, 12'h840 + 12'(w - 2)};
        i_lcw_host_model.mem(1'h1, ma, hi);
        i_lcw_host_model.mem(1'h0, ma, 8'h00);
        chk(O_MEM_RDATA, hi);
      end
      wr(off, sl);
      wr(off + 6'h01, ub);
      wr(off + 6'h02, sl + 8'h10);
      wr(off + 6'h03, ub);
      // Enable only windows programmed so far; stale bytes cannot hit
      wr(lcw_pkg::OFF_WIN_ENA, ena);
      for (int k = 0; k < 4; k++) begin
        d = 8'($random(seed));
        a = {hi, sl + dl[k]};
        if (w < 2) begin
          i_lcw_host_model.io(d[7], a, d);
          chk(O_CARD_IO_SEL, k < 2);
          if (k < 2) chk(O_CARD_ADDR, {10'h000, a + ofs});
          if (k < 2) chk(O_WDATA, d);
          if (k < 2) chk(O_CARD_WRITE, d[7]);
        end else begin
          ma = {hi, 4'(hi), sl + dl[k], 12'($random(seed))};
          i_lcw_host_model.mem(d[7], ma, d);
          chk(O_CARD_MEM_SEL, k < 2);
          if (k < 2) chk(O_CARD_ADDR, mem_card(ma, ofs[13:0]));
          if (k < 2) chk(O_WDATA, d);
          if (k < 2) chk(O_CARD_WRITE, d[7]);
        end
      end
    end
    $display("window test done");
    i_lcw_host_model.mem(1'h1, {I_SOCKET_BASE, 12'h7FF}, 8'h00);
    chk(O_SOCK_SEL, 1'h1);
    chk(O_SOCK_OFF, 11'h7FF);
    chk(O_CARD_WRITE, 1'h1);
    i_lcw_host_model.mem(1'h0, {I_SOCKET_BASE, 12'h845}, 8'h00);
    chk(O_MEM_ACK, 1'h0);
    chk(O_SOCK_SEL, 1'h0);
    do_reset();
    chk(O_CARD_RESET, 1'h1);
    rd(8'h08, 8'h00);
    $display("socket and second reset test done");
    conclude();
  end
endmodule

bind lcw_top lcw_checker i_lcw_checker (.I_CLK, .I_RST, .I_LEGACY_BASE,
  .I_SOCKET_BASE, .I_IO_VALID, .I_IO_ADDR, .I_MEM_VALID, .I_MEM_ADDR,
  .O_IO_ACK, .O_MEM_ACK, .O_SOCK_SEL, .O_SOCK_OFF, .O_CARD_IO_SEL,
  .O_CARD_MEM_SEL, .O_CARD_ADDR, .O_CARD_RESET);
